//--- rtl/blr_line_router.v
// backplane line router: two routing registers and the line paths
// assumes a simple 16-bit register port on REF_CLK_I, pins asynchronous
`include "blr_defines.vh"
`default_nettype none

module blr_line_router #(
	parameter IRQ_N = 7,
	parameter TRG_N = 8
) (
	// clock and reset
	input wire REF_CLK_I,
	input wire RESETN_I,
	// register port
	input wire [`BLR_ADDR_W-1:0] REG_ADDR_I,
	input wire REG_WR_I,
	input wire REG_RD_I,
	input wire [1:0] REG_BE_I,
	input wire [15:0] REG_WDATA_I,
	output wire [15:0] REG_RDATA_O,
	output wire REG_ACK_O,
	// backplane interrupt request lines 7..1 as bits 6..0
	input wire [IRQ_N-1:0] BP_IRQ_N_I,
	output wire [IRQ_N-1:0] BP_IRQ_O,
	output wire [IRQ_N-1:0] BP_IRQ_OE_N_O,
	// extension interrupt lines
	input wire [IRQ_N-1:0] EXT_IRQ_N_I,
	output wire [IRQ_N-1:0] EXT_IRQ_O,
	output wire [IRQ_N-1:0] EXT_IRQ_OE_N_O,
	// backplane ttl trigger lines 7..0
	input wire [TRG_N-1:0] BP_TRG_N_I,
	output wire [TRG_N-1:0] BP_TRG_O,
	output wire [TRG_N-1:0] BP_TRG_OE_N_O,
	// extension trigger lines
	input wire [TRG_N-1:0] EXT_TRG_N_I,
	output wire [TRG_N-1:0] EXT_TRG_O,
	output wire [TRG_N-1:0] EXT_TRG_OE_N_O
);

	// ==========================================================
	// routing registers
	reg [IRQ_N-1:0] irq_route_enable_r;
	reg [IRQ_N-1:0] irq_route_direction_r;
	reg [TRG_N-1:0] trigger_route_enable_r;
	reg [TRG_N-1:0] trigger_route_direction_r;
	reg [15:0] rdata_r;
	reg [15:0] rdata_nxt;
	reg ack_r;
	wire [15:0] irq_rst;
	wire [15:0] trg_rst;
	wire sel_irq;
	wire sel_trg;
	wire [15:0] irq_view;
	wire [15:0] trg_view;

	assign irq_rst = `BLR_IRQ_ROUTE_RST;
	assign trg_rst = `BLR_TRG_ROUTE_RST;

	// bit 0 of the address picks a byte lane and is ignored here
	assign sel_irq = ({REG_ADDR_I[`BLR_ADDR_W-1:1], 1'b0} ==
		`BLR_IRQ_ROUTE_OFS);
	assign sel_trg = ({REG_ADDR_I[`BLR_ADDR_W-1:1], 1'b0} ==
		`BLR_TRG_ROUTE_OFS);

	// ==========================================================
	// register writes; byte lanes let 8-bit masters set one half
	always @(posedge REF_CLK_I) begin
		if (!RESETN_I) begin
			// hard reset disables all routing
			irq_route_enable_r <=
				irq_rst[`BLR_IRQ_EN_MSB:`BLR_IRQ_EN_LSB];
			irq_route_direction_r <=
				irq_rst[`BLR_IRQ_DIR_MSB:`BLR_IRQ_DIR_LSB];
			trigger_route_enable_r <=
				trg_rst[`BLR_TRG_EN_MSB:`BLR_TRG_EN_LSB];
			trigger_route_direction_r <=
				trg_rst[`BLR_TRG_DIR_MSB:`BLR_TRG_DIR_LSB];
		end else if (REG_WR_I) begin
			if (sel_irq && REG_BE_I[1]) begin
				// bit 15 is dropped on write
				irq_route_enable_r <=
					REG_WDATA_I[`BLR_IRQ_EN_MSB:`BLR_IRQ_EN_LSB];
			end
			if (sel_irq && REG_BE_I[0]) begin
				// bit 7 is dropped on write
				irq_route_direction_r <=
					REG_WDATA_I[`BLR_IRQ_DIR_MSB:`BLR_IRQ_DIR_LSB];
			end
			if (sel_trg && REG_BE_I[1]) begin
				trigger_route_enable_r <=
					REG_WDATA_I[`BLR_TRG_EN_MSB:`BLR_TRG_EN_LSB];
			end
			if (sel_trg && REG_BE_I[0]) begin
				trigger_route_direction_r <=
					REG_WDATA_I[`BLR_TRG_DIR_MSB:`BLR_TRG_DIR_LSB];
			end
		end
	end

	// ==========================================================
	// read back
	assign irq_view = {1'b0, irq_route_enable_r,
		1'b0, irq_route_direction_r};
	assign trg_view = {trigger_route_enable_r, trigger_route_direction_r};

	always @* begin
		rdata_nxt = rdata_r;
		if (REG_RD_I && !REG_WR_I) begin
			if (sel_irq) begin
				rdata_nxt = irq_view;
			end else if (sel_trg) begin
				rdata_nxt = trg_view;
			end else begin
				// unmapped offsets read as zero
				rdata_nxt = 16'h0000;
			end
		end
	end

	always @(posedge REF_CLK_I) begin
		if (!RESETN_I) begin
			rdata_r <= 16'h0000;
			ack_r <= 1'b0;
		end else begin
			rdata_r <= rdata_nxt;
			ack_r <= REG_RD_I | REG_WR_I;
		end
	end

	assign REG_RDATA_O = rdata_r;
	assign REG_ACK_O = ack_r;

	// ==========================================================
	// line paths
	blr_line_path #(
		.N(IRQ_N)
	) u_irq (
		.clk_i(REF_CLK_I),
		.rst_n_i(RESETN_I),
		.en_i(irq_route_enable_r),
		.dir_i(irq_route_direction_r),
		.bp_n_i(BP_IRQ_N_I),
		.bp_o(BP_IRQ_O),
		.bp_oe_n_o(BP_IRQ_OE_N_O),
		.ext_o(EXT_IRQ_O),
		.ext_oe_n_o(EXT_IRQ_OE_N_O),
		.ext_n_i(EXT_IRQ_N_I)
	);

	blr_line_path #(
		.N(TRG_N)
	) u_trg (
		.clk_i(REF_CLK_I),
		.rst_n_i(RESETN_I),
		.en_i(trigger_route_enable_r),
		.dir_i(trigger_route_direction_r),
		.bp_n_i(BP_TRG_N_I),
		.bp_o(BP_TRG_O),
		.bp_oe_n_o(BP_TRG_OE_N_O),
		.ext_o(EXT_TRG_O),
		.ext_oe_n_o(EXT_TRG_OE_N_O),
		.ext_n_i(EXT_TRG_N_I)
	);

endmodule

`default_nettype wire

//--- rtl/blr_defines.vh
// constants for the backplane line router: offsets, fields, resets
// assumes a 16-bit register port with byte-address offsets
//
// Function
// - irq register bits 15 and 7 read zero, ignored
// - irq enables in bits 14..8, lines 7..1
// - irq directions in bits 6..0, lines 7..1
// - disabled irq line routed in neither direction
// - irq dir 0: backplane line drives extension line
// - irq dir 1: extension line drives backplane line
// - hard reset clears all irq and trigger enables
// - trigger enables in bits 15..8, lines 7..0
// - disabled trigger line routed in neither direction
// - trigger directions bits 7..0; 0: backplane drives extension
// - trigger dir 1: extension drives backplane line
// - irq routing register, 16-bit, offset 12 hex
// - trigger routing register, 16-bit, offset 14 hex
`ifndef BLR_DEFINES_VH
`define BLR_DEFINES_VH

// ==========================================================
// register offsets (byte address from register base)
`define BLR_ADDR_W 6
`define BLR_IRQ_ROUTE_OFS 6'h12
`define BLR_TRG_ROUTE_OFS 6'h14

// ==========================================================
// field positions
`define BLR_IRQ_EN_MSB 14
`define BLR_IRQ_EN_LSB 8
`define BLR_IRQ_DIR_MSB 6
`define BLR_IRQ_DIR_LSB 0
`define BLR_TRG_EN_MSB 15
`define BLR_TRG_EN_LSB 8
`define BLR_TRG_DIR_MSB 7
`define BLR_TRG_DIR_LSB 0

// ==========================================================
// reset values
`define BLR_IRQ_ROUTE_RST 16'h0000
`define BLR_TRG_ROUTE_RST 16'h0000

`endif

//--- rtl/blr_line_path.v
// per-line routing of a group of open-drain, active-low lines
// assumes pins come from outside the clock domain
`default_nettype none

module blr_line_path #(
	parameter N = 8
) (
	// clock and reset
	input wire clk_i,
	input wire rst_n_i,
	// routing control
	input wire [N-1:0] en_i,
	input wire [N-1:0] dir_i,
	// backplane side
	input wire [N-1:0] bp_n_i,
	output wire [N-1:0] bp_o,
	output wire [N-1:0] bp_oe_n_o,
	// extension side
	output wire [N-1:0] ext_o,
	output wire [N-1:0] ext_oe_n_o,
	input wire [N-1:0] ext_n_i
);

	// open drain: the pin data is always low, only the enable moves
	assign bp_o = {N{1'b0}};
	assign ext_o = {N{1'b0}};

	genvar g;
	generate
		for (g = 0; g < N; g = g + 1) begin : line
			reg bp_s1_r;
			reg bp_s2_r;
			reg ext_s1_r;
			reg ext_s2_r;
			reg bp_oe_n_r;
			reg ext_oe_n_r;
			wire to_ext;
			wire to_bp;

			// ==========================================================
			// two-flop synchronisers, idle high
			always @(posedge clk_i) begin
				if (!rst_n_i) begin
					bp_s1_r <= 1'b1;
					bp_s2_r <= 1'b1;
					ext_s1_r <= 1'b1;
					ext_s2_r <= 1'b1;
				end else begin
					bp_s1_r <= bp_n_i[g];
					bp_s2_r <= bp_s1_r;
					ext_s1_r <= ext_n_i[g];
					ext_s2_r <= ext_s1_r;
				end
			end

			// ==========================================================
			// drive decision; a disabled line never pulls either side
			assign to_ext = en_i[g] & ~dir_i[g];
			assign to_bp = en_i[g] & dir_i[g];

			// the driven side is never the sampled source, so no loop
			always @(posedge clk_i) begin
				if (!rst_n_i) begin
					bp_oe_n_r <= 1'b1;
					ext_oe_n_r <= 1'b1;
				end else begin
					// level follow, no latching
					ext_oe_n_r <= ~(to_ext & ~bp_s2_r);
					bp_oe_n_r <= ~(to_bp & ~ext_s2_r);
				end
			end

			assign bp_oe_n_o[g] = bp_oe_n_r;
			assign ext_oe_n_o[g] = ext_oe_n_r;
		end
	endgenerate

endmodule

`default_nettype wire

//--- tb/blr_asserts.sv
// port checker for the line router
// assumes it is bound onto blr_line_router
`include "blr_defines.vh"
`default_nettype none
// ====
module blr_asserts #(parameter IRQ_N = 7, parameter TRG_N = 8) (
	input wire logic REF_CLK_I, RESETN_I, REG_WR_I, REG_RD_I, REG_ACK_O,
	input wire logic [`BLR_ADDR_W-1:0] REG_ADDR_I,
	input wire logic [15:0] REG_RDATA_O,
	input wire logic [IRQ_N-1:0] EXT_IRQ_N_I, BP_IRQ_OE_N_O, EXT_IRQ_OE_N_O,
	input wire logic [TRG_N-1:0] BP_TRG_N_I, BP_TRG_OE_N_O, EXT_TRG_OE_N_O
);
	timeunit 1ns;
	timeprecision 1ps;
	wire logic [5:0] wa = {REG_ADDR_I[5:1], 1'b0};
	wire logic rd = REG_RD_I && !REG_WR_I;
	default clocking @(posedge REF_CLK_I); endclocking
	default disable iff (!RESETN_I);
	chk_ack_after: assert property (
		REG_WR_I || REG_RD_I |=> REG_ACK_O) else $error("no ack");
	chk_ack_single: assert property (
		!(REG_WR_I || REG_RD_I) |=> !REG_ACK_O) else $error("stray ack");
	chk_irq_zero_bits: assert property (
		rd && wa == `BLR_IRQ_ROUTE_OFS |=> !(REG_RDATA_O[15] || REG_RDATA_O[7]))
		else $error("zero bit set");
	chk_unmapped_zero: assert property (
		rd && wa != `BLR_IRQ_ROUTE_OFS && wa != `BLR_TRG_ROUTE_OFS
		|=> REG_RDATA_O == 0) else $error("unmapped read not zero");
	chk_reset_release: assert property (
		$rose(RESETN_I) |-> &{BP_IRQ_OE_N_O, EXT_IRQ_OE_N_O,
		BP_TRG_OE_N_O, EXT_TRG_OE_N_O}) else $error("driven after reset");
	chk_one_way: assert property (
		&(BP_IRQ_OE_N_O | EXT_IRQ_OE_N_O) && &(BP_TRG_OE_N_O | EXT_TRG_OE_N_O))
		else $error("line driven both ways");
	// source seen three edges back: two sync flops and the output flop
	chk_ext_trg_src: assert property (
		(~EXT_TRG_OE_N_O & $past(BP_TRG_N_I, 3)) == 0)
		else $error("trigger driven without source");
	chk_bp_irq_src: assert property (
		(~BP_IRQ_OE_N_O & $past(EXT_IRQ_N_I, 3)) == 0)
		else $error("irq driven without source");
endmodule
bind blr_line_router blr_asserts #(.IRQ_N(IRQ_N), .TRG_N(TRG_N)) u_chk (
	.REF_CLK_I, .RESETN_I, .REG_WR_I, .REG_RD_I, .REG_ACK_O, .REG_ADDR_I,
	.REG_RDATA_O, .EXT_IRQ_N_I, .BP_IRQ_OE_N_O, .EXT_IRQ_OE_N_O,
	.BP_TRG_N_I, .BP_TRG_OE_N_O, .EXT_TRG_OE_N_O);
`default_nettype wire

//--- tb/blr_far_lines.sv
// far-side open-drain lines with pull-ups
// assumes the router pulls low only with oe_n low
`default_nettype none
// ====
module blr_far_lines #(parameter N = 8) (
	input wire logic [N-1:0] pull_n_i,
	input wire logic [N-1:0] oe_n_i,
	output logic [N-1:0] lvl_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// an unknown enable before reset counts as released, not as low
	always_comb begin
		for (int k = 0; k < N; k++)
			lvl_o[k] = pull_n_i[k] && oe_n_i[k] !== 1'b0;
	end
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// bench for the line router against a register and line model
// assumes pull-ups on every far line
`include "blr_defines.vh"
`default_nettype none
// ====
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int RI = `BLR_IRQ_ROUTE_OFS >> 1;
	localparam int RT = `BLR_TRG_ROUTE_OFS >> 1;
	logic clk = 0, rst_n = 0, wr = 0, rd = 0, ack;
	logic [5:0] adr = 0;
	logic [1:0] be = 0;
	logic [15:0] wd = 0, rdat, m [32];
	logic [6:0] bip = '1, eip = '1, bil, eil, bio, eio;
	logic [7:0] btp = '1, etp = '1, btl, etl, bto, eto;
	logic [6:0] bpd, epd;
	logic [7:0] btd, etd;
	logic [31:0] sd = 59898;
	int mismatches = 0, n_compared = 0;
	blr_line_router u_blr_line_router (.REF_CLK_I(clk), .RESETN_I(rst_n),
		.REG_ADDR_I(adr), .REG_WR_I(wr), .REG_RD_I(rd), .REG_BE_I(be),
		.REG_WDATA_I(wd), .REG_RDATA_O(rdat), .REG_ACK_O(ack),
		.BP_IRQ_N_I(bil), .BP_IRQ_O(bpd), .BP_IRQ_OE_N_O(bio),
		.EXT_IRQ_N_I(eil), .EXT_IRQ_O(epd), .EXT_IRQ_OE_N_O(eio),
		.BP_TRG_N_I(btl), .BP_TRG_O(btd), .BP_TRG_OE_N_O(bto),
		.EXT_TRG_N_I(etl), .EXT_TRG_O(etd), .EXT_TRG_OE_N_O(eto));
	blr_far_lines #(7) u_bi (.pull_n_i(bip), .oe_n_i(bio), .lvl_o(bil));
	blr_far_lines #(7) u_ei (.pull_n_i(eip), .oe_n_i(eio), .lvl_o(eil));
	blr_far_lines #(8) u_bt (.pull_n_i(btp), .oe_n_i(bto), .lvl_o(btl));
	blr_far_lines #(8) u_et (.pull_n_i(etp), .oe_n_i(eto), .lvl_o(etl));
	initial forever #20 clk = ~clk;
	function automatic logic [15:0] rnd();
		sd ^= sd << 13;
		sd ^= sd >> 17;
		sd ^= sd << 5;
		return sd[15:0];
	endfunction
	task automatic chk(input logic [15:0] s, e);
		n_compared++;
		if (s !== e) begin
			mismatches++;
			$display("wrong value at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic give_verdict();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// strobe stays up between back-to-back accesses; lines() drops it
	task automatic acc(input logic w, input logic [5:0] a);
		logic [15:0] k, f;
		be = 2'(rnd());
		wd = rnd();
		wr = w;
		rd = !w;
		adr = a;
		k = {{8{be[1]}}, {8{be[0]}}};
		f = a[5:1] == RI ? 16'h7f7f : a[5:1] == RT ? 16'hffff : 16'h0000;
		@(posedge clk);
		#1;
		chk(16'(ack), 16'h0001);
		if (w)
			m[a[5:1]] = (m[a[5:1]] & ~k | wd & k) & f;
		else
			chk(rdat, m[a[5:1]]);
	endtask
	task automatic lines();
		logic [15:0] i, t;
		wr = 0;
		rd = 0;
		i = m[RI];
		t = m[RT];
		{bip, eip} = 14'(rnd());
		{btp, etp} = rnd();
		// one edge beyond the two sync flops and the output flop lets a flipped direction settle
		repeat (4) @(posedge clk);
		#1;
		chk(16'(eio), 7'(~(i[14:8] & ~i[6:0] & ~bip)));
		chk(16'(bio), 7'(~(i[14:8] & i[6:0] & ~eip)));
		chk(16'(eto), 8'(~(t[15:8] & ~t[7:0] & ~btp)));
		chk(16'(bto), 8'(~(t[15:8] & t[7:0] & ~etp)));
		chk(16'({bpd, epd}), 16'h0000);
		chk({btd, etd}, 16'h0000);
	endtask
	task automatic do_reset(input int n);
		rst_n = 0;
		m = '{default: 16'h0000};
		repeat (n) @(posedge clk);
		#1;
		rst_n = 1;
	endtask
	initial begin
		#1;
		do_reset(12);
		for (int r = 0; r < 2; r++) begin
			acc(0, `BLR_IRQ_ROUTE_OFS);
			acc(0, `BLR_TRG_ROUTE_OFS);
			lines();
			for (int n = 0; n < 250; n++) begin
				acc(1, `BLR_IRQ_ROUTE_OFS);
				acc(0, `BLR_IRQ_ROUTE_OFS);
				acc(1, `BLR_TRG_ROUTE_OFS);
				acc(0, `BLR_TRG_ROUTE_OFS);
				acc(1'(rnd()), 6'(rnd()));
				lines();
			end
			$display("test %0d done", r);
			do_reset(3);
		end
		give_verdict();
	end
	initial begin
		#400000;
		mismatches++;
		give_verdict();
	end
endmodule
`default_nettype wire
